// ---- shared/pcc_pkg.sv ----
package pcc_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] PCC_ADDR_PAD_CTRL   = 8'hb5;
  localparam logic [7:0] PCC_ADDR_CLK_IRQ    = 8'hb6;
  localparam logic [7:0] PCC_ADDR_CLKOUT_SET = 8'h8f;

  // ----------------------------------------------------------------
  // port_pad_control fields
  // ----------------------------------------------------------------
  localparam int PCC_CTRL_STROBE     = 7;
  localparam int PCC_CTRL_ROFF       = 6;
  localparam int PCC_CTRL_MATRIX     = 5;
  localparam int PCC_CTRL_DRV2X      = 4;
  localparam int PCC_CTRL_LED_MID    = 3;
  localparam int PCC_CTRL_OTHER_MID  = 2;
  localparam int PCC_CTRL_LED_HI     = 1;
  localparam int PCC_CTRL_LED_LO     = 0;
  localparam logic [7:0] PCC_CTRL_RESET = 8'h0c;

  // ----------------------------------------------------------------
  // port_clock_interrupt_setting fields
  // ----------------------------------------------------------------
  localparam int PCC_SET_B_ANY       = 7;
  localparam int PCC_SET_A_ANY       = 6;
  localparam int PCC_SET_PIN_HI      = 5;
  localparam int PCC_SET_PIN_LO      = 4;
  localparam int PCC_SET_CLKEN       = 3;
  localparam int PCC_SET_REFEN       = 2;
  localparam logic [7:0] PCC_SET_RESET = 8'h00;

  // ----------------------------------------------------------------
  // clock_output_setting fields
  // ----------------------------------------------------------------
  localparam int PCC_CLK_CLEAR       = 7;
  localparam int PCC_CLK_INV         = 6;
  localparam int PCC_CLK_SYM         = 5;
  localparam int PCC_CLK_DIV_HI      = 4;
  localparam int PCC_CLK_DIV_LO      = 0;
  localparam logic [7:0] PCC_CLKSET_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Pad masks, strobe timing and divider width
  // ----------------------------------------------------------------
  localparam logic [7:0] PCC_ROFF_MASK   = 8'h06;
  localparam logic [7:0] PCC_MATRIX_MASK = 8'h0e;
  localparam int PCC_STROBE_CYCLES       = 2;
  localparam int PCC_DIV_WIDTH           = 5;

endpackage : pcc_pkg

// ---- verilog/pcc_port_clock.sv ----
// Operation
// - Strobe 0-1-0 loads pad latches, two clocks
// - Roff readback from pad; pull-ups off GPIO1-2
// - Matrix latched drives GPIO1-3 low, readback
// - Control bit 4 doubles output drive strength
// - Bit 3 GPIO5 threshold, bit 2 others
// - Two-bit field sets LED current level
// - LED on/off follows port data bit 5
// - Edge bit: single polarity edge or any edge
// - Pin select bits make GPIO4/GPIO6 clock outputs
// - Enable gates waveform only, not pin configuration
// - Disable finishes current period, then holds 0 (1 when inverted)
// - Reference enable forces GPIO3 to clock input
// - Output clock from 24 MHz oscillator only
// - Division factors 1 to 31 supported
// - Selectable balanced duty for odd factors
// - Software selects resting level when disabled
// - New factor applied only at period end
// - Inversion at chain end, takes effect immediately
// - Symmetry off: odd halves differ one period
`timescale 1ns/10ps
`default_nettype none

module pcc_port_clock
  import pcc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       osc_rise,
  input  wire logic       osc_fall,
  input  wire logic       port_a_data_led,
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  input  wire logic       ext_irq_a_polarity,
  input  wire logic       ext_irq_b_polarity,
  output logic            ext_irq_a_event,
  output logic            ext_irq_b_event,
  output logic            pad_latch_open,
  output logic            pad_roff,
  output logic            pad_matrix,
  output logic      [7:0] pullup_disable,
  output logic      [7:0] matrix_drive_low,
  output logic            double_drive,
  output logic            led_pin_mid_threshold,
  output logic            other_pins_mid_threshold,
  output logic      [1:0] led_current_level,
  output logic            led_drive_on,
  output logic      [1:0] clkout_pin_select,
  output logic            ref_clock_input,
  output logic            clk_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] high_count(input logic [4:0] div);
    logic [5:0] sum;
    sum = {1'b0, div} + 6'h01;
    high_count = sum[5:1];
  endfunction : high_count

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] ctrl_ff;
  logic [7:0] set_ff;
  logic [6:0] clkset_ff;
  logic [7:0] rdata_ff;
  logic       clr_pulse_ff;

  wire wr_ctrl   = sfr_wr & (sfr_addr == PCC_ADDR_PAD_CTRL);
  wire wr_set    = sfr_wr & (sfr_addr == PCC_ADDR_CLK_IRQ);
  wire wr_clkset = sfr_wr & (sfr_addr == PCC_ADDR_CLKOUT_SET);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= PCC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= sfr_wdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      set_ff <= PCC_SET_RESET;
    end else if (wr_set) begin
      set_ff <= sfr_wdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clkset_ff <= PCC_CLKSET_RESET[6:0];
    end else if (wr_clkset) begin
      clkset_ff <= sfr_wdata[6:0];
    end
  end

  // Clear pulse is registered behind the write
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clr_pulse_ff <= 1'b0;
    end else begin
      clr_pulse_ff <= wr_clkset & sfr_wdata[PCC_CLK_CLEAR];
    end
  end

  // ----------------------------------------------------------------
  // Pad latch transfer
  // ----------------------------------------------------------------
  logic [PCC_STROBE_CYCLES-1:0] open_pipe_ff;
  logic [1:0]                   val_pipe_ff [PCC_STROBE_CYCLES];
  logic                         pad_roff_ff;
  logic                         pad_matrix_ff;

  wire [1:0] strobe_vals = {ctrl_ff[PCC_CTRL_ROFF], ctrl_ff[PCC_CTRL_MATRIX]};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      open_pipe_ff   <= '0;
      val_pipe_ff[0] <= 2'h0;
      val_pipe_ff[1] <= 2'h0;
    end else begin
      open_pipe_ff   <= {open_pipe_ff[0], ctrl_ff[PCC_CTRL_STROBE]};
      val_pipe_ff[0] <= strobe_vals;
      val_pipe_ff[1] <= val_pipe_ff[0];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pad_roff_ff   <= 1'b0;
      pad_matrix_ff <= 1'b0;
    end else if (open_pipe_ff[PCC_STROBE_CYCLES-1]) begin
      pad_roff_ff   <= val_pipe_ff[1][1];
      pad_matrix_ff <= val_pipe_ff[1][0];
    end
  end

  assign pad_latch_open   = open_pipe_ff[PCC_STROBE_CYCLES-1];
  assign pad_roff         = pad_roff_ff;
  assign pad_matrix       = pad_matrix_ff;
  assign pullup_disable   = (pad_roff_ff ? PCC_ROFF_MASK : 8'h00)
                          | (pad_matrix_ff ? PCC_MATRIX_MASK : 8'h00);
  assign matrix_drive_low = pad_matrix_ff ? PCC_MATRIX_MASK : 8'h00;

  // ----------------------------------------------------------------
  // Static pad settings
  // ----------------------------------------------------------------
  assign double_drive             = ctrl_ff[PCC_CTRL_DRV2X];
  assign led_pin_mid_threshold    = ctrl_ff[PCC_CTRL_LED_MID];
  assign other_pins_mid_threshold = ctrl_ff[PCC_CTRL_OTHER_MID];
  assign led_current_level        = ctrl_ff[PCC_CTRL_LED_HI:PCC_CTRL_LED_LO];
  assign led_drive_on             = port_a_data_led & (|led_current_level);
  assign clkout_pin_select        = set_ff[PCC_SET_PIN_HI:PCC_SET_PIN_LO];
  assign ref_clock_input          = set_ff[PCC_SET_REFEN];

  // ----------------------------------------------------------------
  // External interrupt edge detection
  // ----------------------------------------------------------------
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] prev_ff;
  logic [1:0] event_ff;

  wire [1:0] rise_edge = sync2_ff & ~prev_ff;
  wire [1:0] fall_edge = ~sync2_ff & prev_ff;
  wire [1:0] any_edge  = {set_ff[PCC_SET_B_ANY], set_ff[PCC_SET_A_ANY]};
  wire [1:0] neg_pol   = {ext_irq_b_polarity, ext_irq_a_polarity};
  wire [1:0] single    = (neg_pol & fall_edge) | (~neg_pol & rise_edge);
  wire [1:0] nxt_event = (any_edge & (rise_edge | fall_edge)) | (~any_edge & single);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 2'h0;
      sync2_ff <= 2'h0;
      prev_ff  <= 2'h0;
      event_ff <= 2'h0;
    end else begin
      sync1_ff <= {ext_irq_b_pin, ext_irq_a_pin};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      event_ff <= nxt_event;
    end
  end

  assign ext_irq_a_event = event_ff[0];
  assign ext_irq_b_event = event_ff[1];

  // ----------------------------------------------------------------
  // Clock output generator
  // ----------------------------------------------------------------
  logic       running_ff;
  logic [4:0] cnt_ff;
  logic [4:0] act_div_ff;
  logic       q_rise_ff;
  logic       q_fall_ff;
  logic       phase_ff;
  logic       clk_out_ff;
  logic       nxt_running;
  logic [4:0] nxt_cnt;
  logic [4:0] nxt_div;
  logic       nxt_q_rise;

  wire [4:0] req_div    = clkset_ff[PCC_CLK_DIV_HI:PCC_CLK_DIV_LO];
  wire       gen_enable = set_ff[PCC_SET_CLKEN];
  wire [4:0] last_cnt   = act_div_ff - 5'h01;
  wire       period_end = running_ff & (cnt_ff == last_cnt);

  always_comb begin
    nxt_running = running_ff;
    nxt_cnt     = cnt_ff + 5'h01;
    nxt_div     = act_div_ff;
    if (!running_ff || period_end) begin
      nxt_cnt     = 5'h00;
      nxt_running = gen_enable & (req_div != 5'h00);
      nxt_div     = req_div;
    end
    nxt_q_rise = nxt_running & (nxt_cnt < high_count(nxt_div));
  end

  // Counter steps on oscillator rising ticks only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      running_ff <= 1'b0;
      cnt_ff     <= 5'h00;
      act_div_ff <= 5'h00;
      q_rise_ff  <= 1'b0;
    end else if (clr_pulse_ff) begin
      running_ff <= 1'b0;
      cnt_ff     <= 5'h00;
      q_rise_ff  <= 1'b0;
    end else if (osc_rise) begin
      running_ff <= nxt_running;
      cnt_ff     <= nxt_cnt;
      act_div_ff <= nxt_div;
      q_rise_ff  <= nxt_q_rise;
    end
  end

  // Half-period delayed copy and oscillator phase
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q_fall_ff <= 1'b0;
      phase_ff  <= 1'b0;
    end else if (clr_pulse_ff) begin
      q_fall_ff <= 1'b0;
      phase_ff  <= 1'b0;
    end else if (osc_rise) begin
      phase_ff  <= 1'b1;
    end else if (osc_fall) begin
      q_fall_ff <= q_rise_ff;
      phase_ff  <= 1'b0;
    end
  end

  wire div_one   = (act_div_ff == 5'h01);
  wire sym_odd   = clkset_ff[PCC_CLK_SYM] & act_div_ff[0];
  wire gen_raw   = div_one ? (running_ff & phase_ff) :
                   sym_odd ? (q_rise_ff & q_fall_ff) : q_rise_ff;
  wire gen_final = gen_raw ^ clkset_ff[PCC_CLK_INV];

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      clk_out_ff <= 1'b0;
    end else begin
      clk_out_ff <= gen_final;
    end
  end

  assign clk_out = clk_out_ff;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [7:0] rd_ctrl   = {ctrl_ff[PCC_CTRL_STROBE], pad_roff_ff, pad_matrix_ff,
                          ctrl_ff[PCC_CTRL_DRV2X:0]};
  wire [7:0] rd_clkset = {~running_ff, clkset_ff};
  wire [7:0] rd_mux    = (sfr_addr == PCC_ADDR_PAD_CTRL)   ? rd_ctrl   :
                         (sfr_addr == PCC_ADDR_CLK_IRQ)    ? set_ff    :
                         (sfr_addr == PCC_ADDR_CLKOUT_SET) ? rd_clkset : 8'h00;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (sfr_rd) begin
      rdata_ff <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_ff;

endmodule : pcc_port_clock

`default_nettype wire

// ---- tb/pcc_port_clock_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcc_port_clock_assertions
  import pcc_pkg::*;
(
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       osc_rise,
  input wire logic       osc_fall,
  input wire logic       port_a_data_led,
  input wire logic       ext_irq_a_event,
  input wire logic       pad_latch_open,
  input wire logic       pad_roff,
  input wire logic       pad_matrix,
  input wire logic [7:0] pullup_disable,
  input wire logic [7:0] matrix_drive_low,
  input wire logic       double_drive,
  input wire logic [1:0] led_current_level,
  input wire logic       led_drive_on,
  input wire logic [1:0] clkout_pin_select,
  input wire logic       clk_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ------------------------------------------------
  // Register write and output checks
  // ------------------------------------------------
  wire logic ctl_wr = sfr_wr && sfr_addr == PCC_ADDR_PAD_CTRL;
  sequence strobe_on; ctl_wr && sfr_wdata[7]; endsequence
  sequence strobe_off; ctl_wr && !sfr_wdata[7]; endsequence
  sequence quiet; !sfr_wr [*2]; endsequence

  chk_strobe_opens: assert property (strobe_on ##1 quiet |=> pad_latch_open)
    else $error("latch not open");
  chk_strobe_closes: assert property (strobe_off ##1 quiet |=> !pad_latch_open)
    else $error("latch not closed");
  chk_latch_holds: assert property (!pad_latch_open [*2] |=> $stable({pad_roff, pad_matrix}))
    else $error("latch moved");
  chk_roff_pullups: assert property (pad_roff |-> ##[0:1] pullup_disable[2:1] == 2'h3)
    else $error("pull-ups on");
  chk_matrix_low: assert property (pad_matrix |-> ##[0:1]
    (matrix_drive_low[3:1] == 3'h7 && pullup_disable[3:1] == 3'h7))
    else $error("matrix not low");
  chk_drive_bits: assert property (ctl_wr |=>
    {double_drive, led_current_level} == {$past(sfr_wdata[4]), $past(sfr_wdata[1:0])})
    else $error("drive bits");
  chk_led_gate: assert property (led_drive_on == (port_a_data_led && led_current_level != 2'h0))
    else $error("led gate");
  chk_pin_select: assert property (sfr_wr && sfr_addr == PCC_ADDR_CLK_IRQ |=>
    clkout_pin_select == $past(sfr_wdata[5:4]))
    else $error("pin select");
  chk_event_pulse: assert property ($rose(ext_irq_a_event) |=> !ext_irq_a_event)
    else $error("event long");
  chk_osc_only: assert property ((!osc_rise && !osc_fall && !sfr_wr) [*3] |=> $stable(clk_out))
    else $error("clk_out moved");
endmodule : pcc_port_clock_assertions
`default_nettype wire

// ---- tb/pcc_osc_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcc_osc_model (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic osc_run,
  output logic      osc_rise,
  output logic      osc_fall
);
  logic [1:0] phase_ff;
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      phase_ff <= 2'h0;
    end else if (osc_run) begin
      phase_ff <= phase_ff + 2'h1;
    end
  end
  assign osc_rise = osc_run && phase_ff == 2'h0;
  assign osc_fall = osc_run && phase_ff == 2'h2;
endmodule : pcc_osc_model
`default_nettype wire

// ---- tb/pcc_port_clock_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module pcc_port_clock_test
  import pcc_pkg::*;
;
  logic       clock, sys_rst, sfr_wr, sfr_rd, osc_rise, osc_fall, osc_run, rd_seen;
  logic       port_a_data_led, ext_irq_a_pin, ext_irq_b_pin, ext_irq_a_polarity;
  logic       ext_irq_b_polarity, ext_irq_a_event, ext_irq_b_event, pad_latch_open;
  logic       pad_roff, pad_matrix, double_drive, led_drive_on, led_pin_mid_threshold;
  logic       other_pins_mid_threshold, ref_clock_input, clk_out;
  logic [1:0] led_current_level, clkout_pin_select;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, pullup_disable, matrix_drive_low, v;
  logic [7:0] exp_q[$];
  int         error_cnt, checks_done, seed, n, i;

  pcc_port_clock pcc_port_clock_i (.clock, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .osc_rise, .osc_fall, .port_a_data_led, .ext_irq_a_pin, .ext_irq_b_pin,
    .ext_irq_a_polarity, .ext_irq_b_polarity, .ext_irq_a_event, .ext_irq_b_event, .pad_latch_open,
    .pad_roff, .pad_matrix, .pullup_disable, .matrix_drive_low, .double_drive, .led_pin_mid_threshold,
    .other_pins_mid_threshold, .led_current_level, .led_drive_on, .clkout_pin_select,
    .ref_clock_input, .clk_out);
  pcc_osc_model pcc_osc_model_i (.clock, .sys_rst, .osc_run, .osc_rise, .osc_fall);

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clock);
    sfr_rd = 1'b0;
    @(negedge clock);
  endtask : rd
  task automatic edge_cnt(input logic b, input logic lvl, input logic [7:0] e);
    n = 0;
    if (b) ext_irq_b_pin = lvl;
    else ext_irq_a_pin = lvl;
    repeat (8) begin
      @(negedge clock);
      if ((b ? ext_irq_b_event : ext_irq_a_event) === 1'b1) n++;
    end
    cmp(8'(n), e);
  endtask : edge_cnt
  task automatic high_cnt(input int lo, input int hi);
    n = 0;
    repeat (60) begin
      @(negedge clock);
      if (clk_out === 1'b1) n++;
    end
    cmp({7'h00, n >= lo && n <= hi}, 8'h01);
  endtask : high_cnt
  task automatic results();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  always @(posedge clock) rd_seen <= sfr_rd;
  always @(negedge clock) if (rd_seen === 1'b1 && exp_q.size() > 0) cmp(sfr_rdata, exp_q.pop_front());
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #50000;
    error_cnt++;
    results();
  end

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    seed = 10320;
    {sfr_wr, sfr_rd, osc_run, port_a_data_led, ext_irq_a_pin, ext_irq_b_pin} = '0;
    {ext_irq_a_polarity, ext_irq_b_polarity, sfr_addr, sfr_wdata} = '0;
    sys_rst = 1'b1;
    repeat (12) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    rd(PCC_ADDR_PAD_CTRL, PCC_CTRL_RESET);
    rd(PCC_ADDR_CLK_IRQ, PCC_SET_RESET);
    rd(8'h00, 8'h00);
    v = 8'($random(seed));
    wr(PCC_ADDR_PAD_CTRL, {3'h3, v[4:0]});
    rd(PCC_ADDR_PAD_CTRL, {3'h0, v[4:0]});
    cmp({3'h0, double_drive, led_pin_mid_threshold, other_pins_mid_threshold, led_current_level}, {3'h0, v[4:0]});
    for (i = 0; i < 8; i++) begin
      wr(PCC_ADDR_PAD_CTRL, {6'h00, i[1:0]});
      port_a_data_led = i[2];
      @(negedge clock);
      cmp({7'h00, led_drive_on}, {7'h00, i[2] && i[1:0] != 2'h0});
    end
    wr(PCC_ADDR_PAD_CTRL, 8'he0);
    wr(PCC_ADDR_PAD_CTRL, 8'h60);
    repeat (4) @(negedge clock);
    rd(PCC_ADDR_PAD_CTRL, 8'h60);
    cmp(matrix_drive_low, PCC_MATRIX_MASK);
    wr(PCC_ADDR_PAD_CTRL, 8'hc0);
    repeat (4) @(negedge clock);
    wr(PCC_ADDR_PAD_CTRL, 8'h40);
    wr(PCC_ADDR_PAD_CTRL, 8'h20);
    repeat (4) @(negedge clock);
    rd(PCC_ADDR_PAD_CTRL, 8'h40);
    cmp(pullup_disable, PCC_ROFF_MASK);
    for (i = 0; i < 4; i++) begin
      v = 8'($random(seed)) & 8'hc4;
      v[5:4] = i[1:0];
      wr(PCC_ADDR_CLK_IRQ, v);
      rd(PCC_ADDR_CLK_IRQ, v);
      cmp({5'h00, clkout_pin_select, ref_clock_input}, {5'h00, v[5:4], v[2]});
    end
    for (i = 0; i < 4; i++) begin
      wr(PCC_ADDR_CLK_IRQ, {i[1], i[1], 6'h00});
      ext_irq_a_polarity = i[0];
      ext_irq_b_polarity = i[0];
      edge_cnt(1'b0, 1'b1, {7'h00, i[1] | !i[0]});
      edge_cnt(1'b0, 1'b0, {7'h00, i[1] | i[0]});
      edge_cnt(1'b1, 1'b1, {7'h00, i[1] | !i[0]});
      edge_cnt(1'b1, 1'b0, {7'h00, i[1] | i[0]});
    end
    osc_run = 1'b1;
    wr(PCC_ADDR_CLKOUT_SET, 8'h03);
    wr(PCC_ADDR_CLK_IRQ, 8'h18);
    repeat (24) @(negedge clock);
    high_cnt(38, 42);
    wr(PCC_ADDR_CLKOUT_SET, 8'h25);
    repeat (24) @(negedge clock);
    high_cnt(28, 32);
    wr(PCC_ADDR_CLKOUT_SET, 8'ha5);
    rd(PCC_ADDR_CLKOUT_SET, 8'ha5);
    wr(PCC_ADDR_CLK_IRQ, 8'h10);
    repeat (24) @(negedge clock);
    cmp({7'h00, clk_out}, 8'h00);
    rd(PCC_ADDR_CLKOUT_SET, 8'ha5);
    osc_run = 1'b0;
    wr(PCC_ADDR_CLKOUT_SET, 8'h63);
    repeat (3) @(negedge clock);
    cmp({7'h00, clk_out}, 8'h01);
    results();
  end
endmodule : pcc_port_clock_test

bind pcc_port_clock pcc_port_clock_assertions pcc_port_clock_assertions_i (.clock, .sys_rst,
  .sfr_addr, .sfr_wr, .sfr_wdata, .osc_rise, .osc_fall, .port_a_data_led, .ext_irq_a_event,
  .pad_latch_open, .pad_roff, .pad_matrix, .pullup_disable, .matrix_drive_low, .double_drive,
  .led_current_level, .led_drive_on, .clkout_pin_select, .clk_out);
`default_nettype wire
